// ### hw/tsw_stage.sv
// One up-counting timing stage with a terminal compare.
`timescale 1ns/10ps
module tsw_stage
  import tsw_pkg::*;
(
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic srst,
  // Control.
  input wire logic run,
  input wire logic clear,
  input wire logic [24:0] limit,
  // Status.
  output logic [24:0] count,
  output logic done
);

  logic [24:0] count_reg;
  logic [24:0] count_next;

  // Done compares the held count, so it is a level while the stage sits at its limit.
  assign done = (count_reg == limit);
  // Counting holds at the limit so the count never wraps back under it.
  assign count_next = clear ? TSW_CNT_RESET : ((run && !done) ? count_reg + TSW_CNT_ONE : count_reg);
  assign count = count_reg;

  // Counter register.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      count_reg <= TSW_CNT_RESET;
    end else begin
      count_reg <= count_next;
    end
  end

endmodule : tsw_stage

// ### hw/tsw_watchdog.sv
// Two-stage watchdog top: warning then hard restart on a missing service input.
`timescale 1ns/10ps
// Notes on behaviour
// R1: Two cascaded stages; first gives a warning interrupt, second a hard restart.
// R2: Each stage counts up from zero toward its configured timeout.
// R3: Cycle mode: timeout is a cycle count; indication when counter reaches it.
// R4: Time mode: milliseconds and clock 10 kHz to 150 MHz become a cycle count.
// R5: Time mode timeouts span 50 to 500 ms in 10 ms steps.
// R6: Missing service input is a fault; stage one counts only then.
// R7: Host must service more often than the stage one timeout.
// R8: Warning interrupt asserts when stage one reaches its timeout.
// R9: Hard restart asserts when stage two reaches its timeout.
// R10: Each stage counter value appears on its own 25-bit output.
// R11: Expiry flag is low while counting, high once the count expired.
// R12: The warning interrupt starts stage two.
// R13: Reset clears counters and all flags; service returns stage one to zero.
module tsw_watchdog
  import tsw_pkg::*;
#(
  parameter bit TIME_MODE = 1'b0,
  parameter int STAGE1_CYCLES = TSW_DEF_CYCLES,
  parameter int STAGE2_CYCLES = TSW_DEF_CYCLES,
  parameter int STAGE1_MS = TSW_DEF_MS,
  parameter int STAGE2_MS = TSW_DEF_MS,
  parameter int CLK_KHZ = TSW_DEF_CLK_KHZ
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic srst,
  // Service input from the supervised processor.
  input wire logic service_in,
  // Warning and restart.
  output logic warn_irq_out,
  output logic hard_restart_out,
  // Counter values and expiry.
  output logic [24:0] stage_one_value_out,
  output logic [24:0] stage_two_value_out,
  output logic expired_out
);

  // ----------------------------------------------------------------------
  // Timeout selection
  // ----------------------------------------------------------------------
  // Time-mode settings are snapped down to a whole 10 ms step inside the range.
  localparam int S1_MS_CL = (STAGE1_MS < TSW_MS_MIN) ? TSW_MS_MIN : (STAGE1_MS > TSW_MS_MAX) ? TSW_MS_MAX : STAGE1_MS;
  localparam int S2_MS_CL = (STAGE2_MS < TSW_MS_MIN) ? TSW_MS_MIN : (STAGE2_MS > TSW_MS_MAX) ? TSW_MS_MAX : STAGE2_MS;
  localparam int S1_MS = S1_MS_CL - (S1_MS_CL % TSW_MS_STEP); // R5
  localparam int S2_MS = S2_MS_CL - (S2_MS_CL % TSW_MS_STEP); // R5
  localparam int KHZ_CL = (CLK_KHZ < TSW_CLK_KHZ_MIN) ? TSW_CLK_KHZ_MIN :
                          (CLK_KHZ > TSW_CLK_KHZ_MAX) ? TSW_CLK_KHZ_MAX : CLK_KHZ;
  // A limit of zero would flag at once, so both limits are at least one.
  localparam logic [24:0] S1_LIMIT_RAW = TIME_MODE ? tsw_ms_to_cycles(S1_MS, KHZ_CL) : STAGE1_CYCLES[24:0]; // R3 R4
  localparam logic [24:0] S2_LIMIT_RAW = TIME_MODE ? tsw_ms_to_cycles(S2_MS, KHZ_CL) : STAGE2_CYCLES[24:0]; // R3 R4
  localparam logic [24:0] S1_LIMIT = (S1_LIMIT_RAW == TSW_CNT_RESET) ? TSW_CNT_ONE : S1_LIMIT_RAW;
  localparam logic [24:0] S2_LIMIT = (S2_LIMIT_RAW == TSW_CNT_RESET) ? TSW_CNT_ONE : S2_LIMIT_RAW;

  // ----------------------------------------------------------------------
  // Service input synchroniser and edge detect
  // ----------------------------------------------------------------------
  logic svc_meta_reg;
  logic svc_sync_reg;
  logic svc_last_reg;
  logic svc_seen;

  // The processor runs on its own clock, so its pin passes two flops first.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      svc_meta_reg <= 1'b0;
      svc_sync_reg <= 1'b0;
      svc_last_reg <= 1'b0;
    end else begin
      svc_meta_reg <= service_in;
      svc_sync_reg <= svc_meta_reg;
      svc_last_reg <= svc_sync_reg;
    end
  end

  // A rising edge is one service; a stuck-high line is not servicing.
  assign svc_seen = svc_sync_reg && !svc_last_reg;

  // ----------------------------------------------------------------------
  // Stages
  // ----------------------------------------------------------------------
  tsw_state_t state_reg;
  tsw_state_t state_next;
  tsw_flags_t flags_reg;
  tsw_flags_t flags_next;
  logic [24:0] cnt1;
  logic [24:0] cnt2;
  logic done1;
  logic done2;
  logic run1;
  logic run2;
  logic clear1;
  logic clear2;
  logic s1_expire;
  logic s2_expire;

  // A stage that expires in the same cycle as a service keeps its expiry: the timeout wins.
  assign s1_expire = (state_reg == TSW_ST_SERVICED) && done1; // R8
  assign s2_expire = (state_reg == TSW_ST_WARN) && done2; // R9
  // Stage one runs while service is missing and no warning stands yet.
  assign run1 = (state_reg == TSW_ST_SERVICED) && !svc_seen; // R6 R2
  // A winning expiry keeps its count at the limit, so the flag and the value agree.
  assign clear1 = svc_seen && !s1_expire; // R13
  // Stage two runs only once the warning stands.
  assign run2 = (state_reg == TSW_ST_WARN); // R12
  assign clear2 = svc_seen && !s2_expire; // R13

  tsw_stage u_stage1 (
    .sys_clk(sys_clk),
    .srst(srst),
    .run(run1),
    .clear(clear1),
    .limit(S1_LIMIT),
    .count(cnt1),
    .done(done1)
  );

  tsw_stage u_stage2 (
    .sys_clk(sys_clk),
    .srst(srst),
    .run(run2),
    .clear(clear2),
    .limit(S2_LIMIT),
    .count(cnt2),
    .done(done2)
  );

  // ----------------------------------------------------------------------
  // Cascade control
  // ----------------------------------------------------------------------
  // A service during the warning recovers; restart is latched until reset,
  // since the supervised system is being rebooted anyway.
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      TSW_ST_SERVICED: begin
        if (done1) begin
          state_next = TSW_ST_WARN; // R8 R1
        end
      end
      TSW_ST_WARN: begin
        if (done2) begin
          state_next = TSW_ST_RESTART; // R9 R1
        end else if (svc_seen) begin
          state_next = TSW_ST_SERVICED;
        end
      end
      TSW_ST_RESTART: begin
        state_next = TSW_ST_RESTART;
      end
      default: begin
        state_next = TSW_ST_SERVICED;
      end
    endcase
  end

  // Flags are decoded from the next state so outputs leave flops directly.
  // One assignment drives the whole struct, so the packed word has a single driver.
  assign flags_next = tsw_flags_t'{
    warn: (state_next == TSW_ST_WARN) || (state_next == TSW_ST_RESTART), // R8
    restart: (state_next == TSW_ST_RESTART), // R9
    expired: (state_next == TSW_ST_RESTART) // R11
  };

  // State and flag registers.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_reg <= TSW_ST_SERVICED; // R13
      flags_reg <= '0; // R13
    end else begin
      state_reg <= state_next;
      flags_reg <= flags_next;
    end
  end

  // Outputs and counter values come from flops.
  assign warn_irq_out = flags_reg.warn;
  assign hard_restart_out = flags_reg.restart;
  assign expired_out = flags_reg.expired;
  assign stage_one_value_out = cnt1; // R10
  assign stage_two_value_out = cnt2; // R10

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  sequence s_warn_rise;
    !warn_irq_out ##1 warn_irq_out;
  endsequence

  a_warn_at_limit: assert property (@(posedge sys_clk) disable iff (srst) // R8
    s_warn_rise |-> stage_one_value_out == S1_LIMIT)
    else $error("warning rose without stage one at its limit");

  a_restart_at_limit: assert property (@(posedge sys_clk) disable iff (srst) // R9
    $rose(hard_restart_out) |-> stage_two_value_out == S2_LIMIT)
    else $error("restart rose without stage two at its limit");

  a_stage_two_idle: assert property (@(posedge sys_clk) disable iff (srst) // R12
    !warn_irq_out && !$past(warn_irq_out) |-> stage_two_value_out == '0 || $past(svc_seen) || stage_two_value_out == $past(stage_two_value_out))
    else $error("stage two moved without warning");

  a_stage_two_runs: assert property (@(posedge sys_clk) disable iff (srst) // R12 R2
    warn_irq_out && !hard_restart_out && !svc_seen && stage_two_value_out != S2_LIMIT
      |=> stage_two_value_out == $past(stage_two_value_out) + 25'h000_0001)
    else $error("stage two did not count during warning");

  a_service_clears: assert property (@(posedge sys_clk) disable iff (srst) // R13
    svc_seen && !s1_expire && !s2_expire |=> stage_one_value_out == '0 && !hard_restart_out == !$past(hard_restart_out))
    else $error("service did not clear stage one");

  a_stage_one_counts: assert property (@(posedge sys_clk) disable iff (srst) // R6 R2
    !warn_irq_out && !svc_seen && stage_one_value_out != S1_LIMIT
      |=> stage_one_value_out == $past(stage_one_value_out) + 25'h000_0001)
    else $error("stage one did not count without service");

  a_expiry_flag: assert property (@(posedge sys_clk) disable iff (srst) // R11
    expired_out == hard_restart_out)
    else $error("expiry flag disagrees with restart");

  a_restart_holds: assert property (@(posedge sys_clk) disable iff (srst) // R9 R1
    hard_restart_out |=> hard_restart_out [*3])
    else $error("restart dropped without reset");

  a_reset_clears: assert property (@(posedge sys_clk) // R13
    srst |=> !warn_irq_out && !hard_restart_out && !expired_out && stage_one_value_out == '0)
    else $error("reset did not clear outputs");

endmodule : tsw_watchdog

// ### pkg/tsw_pkg.sv
// Package of constants and types for the two-stage watchdog.
package tsw_pkg;

  // ----------------------------------------------------------------------
  // Widths and timing
  // ----------------------------------------------------------------------
  localparam int TSW_CNT_W = 25;
  localparam logic [24:0] TSW_CNT_RESET = 25'h000_0000;
  localparam logic [24:0] TSW_CNT_ONE = 25'h000_0001;
  // Time mode settings: step, span and clock range.
  localparam int TSW_MS_MIN = 50;
  localparam int TSW_MS_MAX = 500;
  localparam int TSW_MS_STEP = 10;
  localparam int TSW_CLK_KHZ_MIN = 10;
  localparam int TSW_CLK_KHZ_MAX = 150000;
  // Default timeouts in cycles and in milliseconds for both stages, and default clock in kHz.
  localparam int TSW_DEF_CYCLES = 5000;
  localparam int TSW_DEF_MS = 50;
  localparam int TSW_DEF_CLK_KHZ = 100000;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    TSW_ST_SERVICED = 2'b00,
    TSW_ST_WARN = 2'b01,
    TSW_ST_RESTART = 2'b11
  } tsw_state_t;

  // Status outputs that travel together.
  typedef struct packed {
    logic warn;
    logic restart;
    logic expired;
  } tsw_flags_t;

  // Milliseconds at a clock rate in kHz gives a cycle count, clipped to the counter.
  function automatic logic [24:0] tsw_ms_to_cycles(input int ms, input int khz);
    longint prod;
    prod = longint'(ms) * longint'(khz);
    if (prod > 64'sd33554431) begin
      return 25'h1FF_FFFF;
    end
    return prod[24:0];
  endfunction : tsw_ms_to_cycles

endpackage : tsw_pkg

// ### testbench/tsw_host.sv
// Host model that services the watchdog at a programmable period.
`timescale 1ns/10ps
module tsw_host (
  // Clock.
  input wire logic sys_clk,
  // Control from the bench.
  input wire logic enable,
  input wire logic [7:0] period,
  // Service pin towards the watchdog.
  output logic service_in
);
  logic [7:0] tick_reg;

  initial begin
    tick_reg = 8'h00;
    service_in = 1'b0;
  end

  // The pin is high for two cycles in each period, so every rise has at least two low samples before it.
  // A stopped host leaves the pin low, which the watchdog must read as a missing service.
  // A period of one to four holds the pin stuck high, which must not count as servicing.
  always @(negedge sys_clk) begin
    if (!enable || period == 8'h00) begin
      tick_reg <= 8'h00;
      service_in <= 1'b0;
    end else if (period < 8'h05) begin
      tick_reg <= 8'h00;
      service_in <= 1'b1;
    end else begin
      tick_reg <= (tick_reg + 8'h01 >= period) ? 8'h00 : tick_reg + 8'h01;
      service_in <= (tick_reg < 8'h02);
    end
  end
endmodule : tsw_host

// ### testbench/two_stage_watchdog_test.sv
// Self-checking testbench of the two-stage watchdog.
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin num_errors++; \
  $display("[FAIL] %s expected %0h seen %0h", nm, exp, got); end end
module two_stage_watchdog_test;
  import tsw_pkg::*;
  // ----------------------------------------------------------------------
  // Set-up
  // ----------------------------------------------------------------------
  typedef struct {logic [7:0] period; int cycles; logic warn; logic restart;} tsw_row_t;
  localparam int S1 = 20;
  localparam int S2 = 30;
  localparam logic [24:0] S1_LIM = 25'h000_0014;
  localparam logic [24:0] S2_LIM = 25'h000_001E;
  // Time mode: 50 ms at 10 kHz, and 55 ms which floors to 50 ms.
  localparam logic [24:0] TIME_LIM = 25'h000_01F4;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic host_en = 1'b0;
  logic [7:0] host_period = 8'h00;
  logic service_in;
  logic warn, restart, expired, tw_warn, tw_restart, tw_expired;
  logic [24:0] stage_one, stage_two, tw_one, tw_two, prev;
  logic [3:0] watch;
  int num_errors = 0;
  int checks = 0;
  int n;
  tsw_row_t rows [5] = '{'{8'h08, 200, 1'b0, 1'b0}, '{8'h10, 300, 1'b0, 1'b0},
                         '{8'h00, S1 + 8, 1'b1, 1'b0}, '{8'h00, S1 + S2 + 10, 1'b1, 1'b1},
                         '{8'h01, S1 + 12, 1'b1, 1'b0}};

  always #2.5 sys_clk = ~sys_clk;
  assign watch = {tw_restart, tw_warn, restart, warn};

  tsw_host host (.sys_clk(sys_clk), .enable(host_en), .period(host_period), .service_in(service_in));
  tsw_watchdog #(.STAGE1_CYCLES(S1), .STAGE2_CYCLES(S2)) uut (.sys_clk(sys_clk), .srst(srst),
    .service_in(service_in), .warn_irq_out(warn), .hard_restart_out(restart), .stage_one_value_out(stage_one),
    .stage_two_value_out(stage_two), .expired_out(expired));
  tsw_watchdog #(.TIME_MODE(1'b1), .STAGE1_MS(50), .STAGE2_MS(55), .CLK_KHZ(10)) uut_time (.sys_clk(sys_clk),
    .srst(srst), .service_in(service_in), .warn_irq_out(tw_warn), .hard_restart_out(tw_restart),
    .stage_one_value_out(tw_one), .stage_two_value_out(tw_two), .expired_out(tw_expired));

  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic run(input int cyc);
    repeat (cyc) @(negedge sys_clk);
  endtask : run

  // Reset is held for two cycles, with the host stopped.
  // Host controls change by non-blocking assignment, so the host reads them at its next edge without a race.
  task automatic do_reset();
    host_en <= 1'b0;
    srst = 1'b1;
    run(2);
    `CHK("reset_flags", 3'b000, {warn, restart, expired})
    `CHK("reset_counts", 50'h0, {stage_one, stage_two})
    srst = 1'b0;
  endtask : do_reset

  // Waits a bounded number of cycles for one watched flag to rise.
  task automatic wait_bit(input int idx, input int lim);
    int k;
    k = 0;
    while (watch[idx] !== 1'b1) begin
      if (k == lim) begin
        num_errors++;
        $display("[FAIL] wait_flag expected 1 seen 0");
        wrap_up();
      end
      k++;
      run(1);
    end
  endtask : wait_bit

  task automatic wrap_up();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : wrap_up

  // ----------------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------------
  initial begin
    run(1);
    // Ordinary cases: a live host at two periods, a silent host for one and both stages, a stuck-high pin.
    foreach (rows[i]) begin
      do_reset();
      host_period <= rows[i].period;
      host_en <= 1'b1;
      run(rows[i].cycles);
      `CHK("row_warn", rows[i].warn, warn)
      `CHK("row_restart", rows[i].restart, restart)
      `CHK("row_expired", rows[i].restart, expired)
    end
    // Stage one steps by one per cycle while stage two rests.
    do_reset();
    run(2);
    for (int i = 0; i < 8; i++) begin
      prev = stage_one;
      run(1);
      `CHK("s1_step", prev + TSW_CNT_ONE, stage_one)
      `CHK("s2_rest", TSW_CNT_RESET, stage_two)
    end
    // Warning appears only once stage one reaches its limit.
    n = 0;
    while (stage_one !== S1_LIM && n < S1 + 20) begin
      `CHK("warn_early", 1'b0, warn)
      run(1);
      n++;
    end
    `CHK("s1_limit", S1_LIM, stage_one)
    wait_bit(0, 3);
    // Stage two runs while stage one holds; restart waits for the second limit.
    n = 0;
    while (stage_two !== S2_LIM && n < S2 + 20) begin
      `CHK("restart_early", 1'b0, restart)
      `CHK("expired_early", 1'b0, expired)
      `CHK("s1_hold", S1_LIM, stage_one)
      run(1);
      n++;
    end
    `CHK("s2_limit", S2_LIM, stage_two)
    wait_bit(1, 3);
    `CHK("expired_set", 1'b1, expired)
    `CHK("warn_kept", 1'b1, warn)
    // A service after the restart only zeroes the counters; the restart stays latched.
    host_period <= 8'h08;
    host_en <= 1'b1;
    run(8);
    `CHK("restart_kept", 1'b1, restart)
    `CHK("svc_rst_s2", TSW_CNT_RESET, stage_two)
    // Service during the warning returns both stages to zero.
    do_reset();
    wait_bit(0, S1 + 10);
    host_period <= 8'h08;
    host_en <= 1'b1;
    run(8);
    `CHK("svc_warn", 1'b0, warn)
    `CHK("svc_s1", 1'b0, stage_one > 25'h000_0008)
    `CHK("svc_s2", TSW_CNT_RESET, stage_two)
    // Time mode: milliseconds and kilohertz turn into a cycle count.
    do_reset();
    run(TIME_LIM - 10);
    `CHK("time_early", 1'b0, tw_warn)
    wait_bit(2, 30);
    `CHK("time_s1", TIME_LIM, tw_one)
    wait_bit(3, TIME_LIM + 20);
    `CHK("time_s2", TIME_LIM, tw_two)
    `CHK("time_expired", 1'b1, tw_expired)
    wrap_up();
  end
endmodule : two_stage_watchdog_test
